// >>> hdl/srw_top.sv
// Purpose: Request input, windowing capture, sync and frame pulse control.
// Assumes: Pins arrive asynchronously; registers sit on a plain one-cycle port.
// Notes: Analog delays are reported as step counts, not applied in real time.
//
// Overview of operation
// - Output delay spans 508 steps, four quadrants.
// - Step equals divider over input frequency times 508.
// - Step number chosen by quadrant from I or Q.
// - Total delay is step size times step number.
// - Path select picks generator or repeater bypass.
// - Soft request bit acts like request pin high.
// - Bias field selects input common-mode voltage.
// - Reference edge positions captured for software readback.
// - Internal request edge delayed by programmable steps.
// - Granule code gives 28, 15, 11, 8 ps.
// - Readback valid only after minimum request high time.
// - Sync resets every divider for repeatable phase.
// - Only the physical pin starts a sync.
// - Clock path and multiplier field give functional mode.
// - Mode field: continuous, pulser, or repeater.
`timescale 1ns/1ps
module srw_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic sysref_request_input,
  input wire logic reference_clock_input,
  output logic [1:0] request_input_bias_sel,
  output logic request_internal,
  output logic divider_sync,
  output logic [3:0] frame_pulse_out
);
  import srw_pkg::*;

  logic [31:0] ctrl_q;  // Control register.
  logic [31:0] reqdly_q;  // Request delay count and granule.
  logic [31:0] div_q;  // Frame pulse and interpolator dividers.
  logic [15:0] outdly_q [4];  // Per-output quadrant, I and Q.
  logic [31:0] rdata_q;  // Read data, valid the cycle after the strobe.
  logic [1:0] bias_q;  // Registered copy of the bias field.

  // Field views of the control registers.
  srw_fp_mode_t mode;
  logic [1:0] path_sel;
  logic [5:0] dly_cnt;
  logic [11:0] fp_div;
  assign mode = srw_fp_mode_t'(ctrl_q[CTL_MODE +: 2]);
  assign path_sel = ctrl_q[CTL_PATH +: 2];
  assign dly_cnt = reqdly_q[5:0];
  assign fp_div = div_q[11:0];

  srw_delay_if dif ();
  srw_delay_calc u_calc (
    .dif(dif.calc)
  );
  for (genvar n = 0; n < 4; n++) begin : g_map
    assign dif.quadrant[n] = outdly_q[n][1:0];
    assign dif.inphase[n] = outdly_q[n][8:2];
    assign dif.quadrature[n] = outdly_q[n][15:9];
  end
  assign dif.divider = div_q[16:12];

  // Register writes; the clear bit is a self-clearing pulse so it cannot stick.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RST;
      reqdly_q <= '0;
      div_q <= DIV_RST;
      outdly_q <= '{default: '0};
    end else begin
      ctrl_q[CTL_CAP_CLR] <= 1'b0;
      if (reg_wr) begin
        if (reg_addr == ADDR_CTRL) begin
          ctrl_q <= reg_wdata;
        end
        if (reg_addr == ADDR_REQDLY) begin
          reqdly_q <= {24'h0, reg_wdata[7:0]};
        end
        if (reg_addr == ADDR_DIV) begin
          div_q <= {15'h0, reg_wdata[16:0]};
        end
        for (int n = 0; n < 4; n++) begin
          if (reg_addr == 8'(ADDR_OUTDLY0 + 4 * n)) begin
            outdly_q[n] <= reg_wdata[15:0];
          end
        end
      end
    end
  end

  // Input bias select follows the register into the pad.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bias_q <= '0;
    end else begin
      bias_q <= ctrl_q[CTL_BIAS +: 2];
    end
  end
  assign request_input_bias_sel = bias_q;

  // Two-stage synchronisers for the request pin and the reference clock.
  logic req_s1, req_s2, req_s3;
  logic ref_s1, ref_s2, ref_s3;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {req_s1, req_s2, req_s3} <= '0;
      {ref_s1, ref_s2, ref_s3} <= '0;
    end else begin
      req_s1 <= sysref_request_input;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      ref_s1 <= reference_clock_input;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
    end
  end

  logic req_level;  // Pin or software force, as seen by requests and windowing.
  logic ref_rise;  // Synchronised reference clock rising edge.
  logic sync_edge;  // Pin-only rising edge that may start a sync.
  assign req_level = req_s2 | ctrl_q[CTL_SOFT];
  assign ref_rise = ref_s2 & ~ref_s3;
  assign sync_edge = req_s2 & ~req_s3 & ctrl_q[CTL_SYNC_EN];

  // Delay line for the internal request; each step is one system clock here.
  logic [63:0] req_line_q;
  logic req_int_d, req_int_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      req_line_q <= '0;
      req_int_q <= 1'b0;
    end else begin
      req_line_q <= {req_line_q[62:0], req_level};
      req_int_q <= req_int_d;
    end
  end
  assign req_int_d = (dly_cnt == 6'h0) ? req_level : req_line_q[dly_cnt - 6'h1];
  assign request_internal = req_int_q;

  // Granule code to nominal picoseconds, shown in the status register.
  logic [7:0] gran_ps;
  always_comb begin
    unique case (reqdly_q[7:6])
      2'h0: gran_ps = GRAN_PS0;
      2'h1: gran_ps = GRAN_PS1;
      2'h2: gran_ps = GRAN_PS2;
      2'h3: gran_ps = GRAN_PS3;
    endcase
  end

  // Edge position capture. Completion wins over a clear in the same cycle so
  // that a finished capture is never lost.
  logic req_rise;
  logic armed_q, active_q, pos_valid_q;
  logic [15:0] pos_shift_q, pos_q;
  logic [1:0] ref_cnt_q;
  logic [3:0] hold_cnt_q;
  logic done;
  assign req_rise = req_int_d & ~req_int_q;
  assign done = active_q && req_int_q && ref_cnt_q == REQ_REF_EDGES && hold_cnt_q == '0;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_q <= 1'b1;
      active_q <= 1'b0;
      pos_valid_q <= 1'b0;
      pos_shift_q <= '0;
      pos_q <= '0;
      ref_cnt_q <= '0;
      hold_cnt_q <= '0;
    end else begin
      if (active_q) begin
        pos_shift_q <= {pos_shift_q[14:0], ref_s2};
        if (ref_rise && ref_cnt_q != REQ_REF_EDGES) begin
          ref_cnt_q <= ref_cnt_q + 2'h1;
        end
        if (ref_cnt_q == REQ_REF_EDGES && hold_cnt_q != '0) begin
          hold_cnt_q <= hold_cnt_q - 4'h1;
        end
        if (!req_int_q) begin
          active_q <= 1'b0;  // Request fell too early; stay armed.
        end
      end
      if (done) begin
        pos_q <= {pos_shift_q[14:0], ref_s2};
        pos_valid_q <= 1'b1;
        active_q <= 1'b0;
        armed_q <= 1'b0;
      end else if (ctrl_q[CTL_CAP_CLR]) begin
        pos_valid_q <= 1'b0;
        pos_q <= '0;
        armed_q <= 1'b1;
        active_q <= 1'b0;
      end else if (req_rise && armed_q && ctrl_q[CTL_CAP_EN] && !active_q) begin
        active_q <= 1'b1;
        pos_shift_q <= '0;
        ref_cnt_q <= '0;
        hold_cnt_q <= REQ_EXTRA_CYC;
      end
    end
  end

  // Frame pulse divider and pulser burst counter; sync clears them all.
  logic [11:0] div_cnt_q;
  logic gen_q, sync_q;
  logic [4:0] burst_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_q <= '0;
      gen_q <= 1'b0;
      sync_q <= 1'b0;
      burst_q <= '0;
    end else begin
      sync_q <= sync_edge;
      if (sync_edge) begin
        div_cnt_q <= '0;
        gen_q <= 1'b0;
        burst_q <= '0;
      end else begin
        if (div_cnt_q + 12'h1 >= fp_div) begin
          div_cnt_q <= '0;
          gen_q <= ~gen_q;
          if (gen_q && burst_q != '0) begin  // Count on the fall, so field plus one pulses.
            burst_q <= burst_q - 5'h1;
          end
        end else begin
          div_cnt_q <= div_cnt_q + 12'h1;
        end
        if (mode == FP_PULSER && req_rise) begin
          burst_q <= {1'b0, ctrl_q[CTL_BURST +: 4]} + 5'h1;
        end
      end
    end
  end
  assign divider_sync = sync_q;

  // Generator pulse per mode, then the one path select shared by all four outputs.
  logic gen_pulse, fp_src;
  always_comb begin
    unique case (mode)
      FP_CONT: gen_pulse = gen_q & req_int_q;
      FP_PULSER: gen_pulse = gen_q & (burst_q != '0);
      FP_REPEAT: gen_pulse = req_int_q;
      default: gen_pulse = 1'b0;
    endcase
  end
  // Bypass carries the reclocked request; software pairs it with repeater mode.
  assign fp_src = (path_sel == PATH_BYPASS) ? req_int_q : gen_pulse;
  logic [3:0] fp_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fp_q <= '0;
    end else begin
      fp_q <= {4{fp_src & ctrl_q[CTL_FP_EN]}};
    end
  end
  assign frame_pulse_out = fp_q;

  // Functional mode: 0 buffer, 1 divider, 2 filter, 3 multiplier, 7 invalid.
  logic [2:0] func_mode;
  always_comb begin
    unique case (ctrl_q[CTL_CLK_PATH +: 2])
      2'h1: func_mode = 3'h0;
      2'h2: func_mode = 3'h1;
      2'h3: func_mode = (ctrl_q[CTL_MULT +: 2] == 2'h1) ? 3'h2 : 3'h3;
      default: func_mode = 3'h7;
    endcase
  end

  // Read port: data stands in the cycle after the read strobe only.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          ADDR_CTRL: rdata_q <= ctrl_q;
          ADDR_REQDLY: rdata_q <= reqdly_q;
          ADDR_DIV: rdata_q <= div_q;
          ADDR_STATUS: rdata_q <= {gran_ps, ctrl_q[CTL_FP_EN], func_mode, 3'h0,
            pos_valid_q, pos_q};
          default: begin
            for (int n = 0; n < 4; n++) begin
              if (reg_addr == 8'(ADDR_OUTDLY0 + 4 * n)) begin
                rdata_q <= {16'h0, outdly_q[n]};
              end
              if (reg_addr == 8'(ADDR_STEP0 + 4 * n)) begin
                rdata_q <= {9'h0, dif.total[n], dif.step_num[n]};
              end
            end
          end
        endcase
      end
    end
  end
  assign reg_rdata = rdata_q;

  // Checks on the behaviour above.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_step_max;
    dif.quadrant[0] == 2'h3 ? dif.step_num[0] <= QUAD_STEPS :
      dif.quadrant[0] == 2'h2 ?
      dif.step_num[0] inside {[QUAD_STEPS : 9'(2 * QUAD_STEPS)]} :
      dif.quadrant[0] == 2'h0 ?
      dif.step_num[0] inside {[9'(2 * QUAD_STEPS) : 9'(3 * QUAD_STEPS)]} :
      dif.step_num[0] inside {[9'(3 * QUAD_STEPS) : TOTAL_STEPS]};
  endproperty
  a_step_max: assert property (p_step_max) else $error("step number out of range");

  property p_soft_force;
    ctrl_q[CTL_SOFT] |-> req_level;
  endproperty
  a_soft_force: assert property (p_soft_force) else $error("soft force not applied");

  property p_sync_pin_only;
    sync_q |-> $past(req_s2) && !$past(req_s3);
  endproperty
  a_sync_pin_only: assert property (p_sync_pin_only) else $error("sync without pin edge");

  sequence s_pin_rise;
    req_s2 && !req_s3 && ctrl_q[CTL_SYNC_EN];
  endsequence
  property p_sync_follows;
    s_pin_rise |=> sync_q;
  endproperty
  a_sync_follows: assert property (p_sync_follows) else $error("pin edge did not sync");

  property p_sync_reset;
    sync_q |-> div_cnt_q == '0 && !gen_q;
  endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("dividers not reset");

  property p_hold;
    pos_valid_q && !ctrl_q[CTL_CAP_CLR] |=> pos_valid_q && $stable(pos_q);
  endproperty
  a_hold: assert property (p_hold) else $error("capture changed before clear");

  // Run length of the internal request, so the capture check can see its high time.
  logic [3:0] hi_run_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_run_q <= '0;
    end else if (!req_int_q) begin
      hi_run_q <= '0;
    end else if (hi_run_q != 4'hf) begin
      hi_run_q <= hi_run_q + 4'h1;
    end
  end
  property p_valid_time;
    $rose(pos_valid_q) |-> $past(ref_cnt_q) == REQ_REF_EDGES && $past(req_int_q);
  endproperty
  a_valid_time: assert property (p_valid_time) else $error("readback valid too early");

  property p_valid_after_high;
    $rose(pos_valid_q) |-> $past(hi_run_q) >= 4'h4;
  endproperty
  a_valid_after_high: assert property (p_valid_after_high) else $error("request too short");

  property p_bypass;
    ctrl_q[CTL_FP_EN] && path_sel == PATH_BYPASS |=> fp_q[0] == $past(req_int_q);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass path wrong");

  property p_delay_one;
    $past(dly_cnt) == 6'h1 |-> req_int_q == $past(req_level, 2);
  endproperty
  a_delay_one: assert property (p_delay_one) else $error("request delay wrong");
endmodule

// >>> hdl/srw_pkg.sv
// Purpose: Shared constants for the request window and frame pulse control block.
// Assumes: 200 MHz system clock, 32-bit register port with byte addresses.
// Notes: Offsets and field positions are used by the control and delay modules.
package srw_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_REQDLY = 8'h04;
  localparam logic [7:0] ADDR_DIV = 8'h08;
  localparam logic [7:0] ADDR_OUTDLY0 = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_STEP0 = 8'h30;
  // Control register field positions.
  localparam int CTL_MODE = 0;
  localparam int CTL_FP_EN = 2;
  localparam int CTL_PATH = 3;
  localparam int CTL_SOFT = 5;
  localparam int CTL_BIAS = 6;
  localparam int CTL_CAP_EN = 8;
  localparam int CTL_CAP_CLR = 9;
  localparam int CTL_SYNC_EN = 10;
  localparam int CTL_CLK_PATH = 11;
  localparam int CTL_MULT = 13;
  localparam int CTL_BURST = 15;
  // Reset value of the control register: clock path set to buffer.
  localparam logic [31:0] CTRL_RST = 32'h0000_0800;
  localparam logic [31:0] DIV_RST = 32'h0000_2004;
  // Interpolator step structure.
  localparam logic [8:0] QUAD_STEPS = 9'h07f;
  localparam logic [8:0] TOTAL_STEPS = 9'h1fc;
  // Nominal request delay granules in picoseconds, codes 0 to 3.
  localparam logic [7:0] GRAN_PS0 = 8'h1c;
  localparam logic [7:0] GRAN_PS1 = 8'h0f;
  localparam logic [7:0] GRAN_PS2 = 8'h0b;
  localparam logic [7:0] GRAN_PS3 = 8'h08;
  // Minimum request high time: three reference periods plus an extra time.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int REQ_EXTRA_PS = 1600;
  localparam int REQ_EXTRA_CYC_I = (REQ_EXTRA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] REQ_EXTRA_CYC = 4'(REQ_EXTRA_CYC_I < 1 ? 1 : REQ_EXTRA_CYC_I);
  localparam logic [1:0] REQ_REF_EDGES = 2'h3;
  // Frame pulse modes and delay path codes.
  typedef enum logic [1:0] {
    FP_CONT = 2'b00,
    FP_PULSER = 2'b01,
    FP_REPEAT = 2'b10,
    FP_RSVD = 2'b11
  } srw_fp_mode_t;
  localparam logic [1:0] PATH_BYPASS = 2'h1;
endpackage

// >>> hdl/srw_delay_if.sv
// Purpose: Carries per-output interpolator settings and computed step numbers.
// Assumes: Four frame pulse outputs.
// Notes: The control module drives settings, the calculator returns results.
`timescale 1ns/1ps
interface srw_delay_if;
  logic [1:0] quadrant [4];  // Phase quadrant per output.
  logic [6:0] inphase [4];  // In-phase setting per output.
  logic [6:0] quadrature [4];  // Quadrature setting per output.
  logic [4:0] divider;  // Interpolator clock divider.
  logic [8:0] step_num [4];  // Applied step number per output.
  logic [13:0] total [4];  // Total delay in units of one input period over 508.
  modport ctrl (output quadrant, output inphase, output quadrature, output divider,
    input step_num, input total);
  modport calc (input quadrant, input inphase, input quadrature, input divider,
    output step_num, output total);
endinterface

// >>> hdl/srw_delay_calc.sv
// Purpose: Computes interpolator step number and total delay per output.
// Assumes: Settings are stable register values.
// Notes: Purely combinational; the caller registers what it reads back.
`timescale 1ns/1ps
module srw_delay_calc (
  srw_delay_if.calc dif
);
  import srw_pkg::*;
  // One calculator per output, each picking its base by quadrant.
  for (genvar n = 0; n < 4; n++) begin : g_ch
    logic [8:0] base;  // Quadrant end point.
    logic [8:0] sub;  // Setting subtracted from the end point.
    always_comb begin
      unique case (dif.quadrant[n])
        2'h3: begin
          base = QUAD_STEPS;
          sub = {2'h0, dif.inphase[n]};
        end
        2'h2: begin
          base = 9'(2 * QUAD_STEPS);
          sub = {2'h0, dif.quadrature[n]};
        end
        2'h0: begin
          base = 9'(3 * QUAD_STEPS);
          sub = {2'h0, dif.inphase[n]};
        end
        2'h1: begin
          base = TOTAL_STEPS;
          sub = {2'h0, dif.quadrature[n]};
        end
      endcase
    end
    // The step is divider/(fin*508), so the total is divider times steps.
    assign dif.step_num[n] = base - sub;
    // Both factors are widened first so the product is not cut to nine bits.
    assign dif.total[n] = 14'(dif.divider) * 14'(dif.step_num[n]);
  end
endmodule

// >>> verification/srw_req_source.sv
// Purpose: Upstream timing source that drives the request pin and the reference samples.
// Assumes: The bench starts request pulses through the pulse task only.
// Notes: The reference toggles every two clock cycles and runs free, as a clock should.
`timescale 1ns/1ps
module srw_req_source (
  input wire logic mclk,
  output logic req_pin,
  output logic ref_clk
);
  int now; // Free running cycle count.
  int last_rise; // Cycle of the previous rising edge on the pin.
  logic [1:0] div_q; // Divider that shapes the reference pattern.

  // The pin idles low, so every mode switch of the device sees a low pin.
  initial begin
    req_pin = 1'b0;
    ref_clk = 1'b0;
    now = 0;
    last_rise = -1000;
    div_q = 2'h0;
  end

  // Reference pattern with a period of four system cycles.
  always @(posedge mclk) begin
    now <= now + 1;
    div_q <= div_q + 2'h1;
    ref_clk <= div_q[1];
  end

  // One pulse of hi cycles; rising edges are spaced out even when a caller hurries.
  task automatic pulse(input int hi);
    while (now - last_rise < 80) @(posedge mclk);
    req_pin <= 1'b1;
    last_rise = now;
    repeat (hi) @(posedge mclk); // Sync callers pass more than six cycles.
    req_pin <= 1'b0; // Ends low, the level it started at.
    @(posedge mclk);
  endtask
endmodule

// >>> verification/test_srw_top.sv
// Purpose: Self-checking bench for the request window and frame pulse control block.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes: Reads note their expectation in a queue; a monitor compares under a mask.
`timescale 1ns/1ps
module test_srw_top;
  import srw_pkg::*;
  typedef struct {logic [31:0] exp; logic [31:0] mask;} srw_exp_t;
  logic mclk, sys_rst, reg_wr, reg_rd, req_pin, ref_clk, req_int, div_sync;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0] bias_sel;
  logic [3:0] fp_out;
  srw_exp_t exp_q [$]; // Expected read data, oldest first.
  srw_exp_t mon_e; // Note taken off the queue by the monitor.
  logic rd_seen, pin_q, int_q; // Delayed copies for read timing and edge detection.
  int num_errors, comparisons, seed, tick, t0, lat, ri_cnt, sync_cnt, n0, l0, b;
  logic [4:0] d; // Interpolator divider under test.
  logic [6:0] iv, qv; // Random in-phase and quadrature settings.
  logic [8:0] st; // Expected step number.
  logic [7:0] gran [4] = '{8'h1c, 8'h0f, 8'h0b, 8'h08}; // Granules in ps.
  logic [2:0] fmode [5] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h3}; // Function modes per case.

  always #2.5 mclk = ~mclk;

  srw_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sysref_request_input(req_pin),
    .reference_clock_input(ref_clk), .request_input_bias_sel(bias_sel),
    .request_internal(req_int), .divider_sync(div_sync), .frame_pulse_out(fp_out));
  srw_req_source i_src (.mclk(mclk), .req_pin(req_pin), .ref_clk(ref_clk));

  // Compares read data in the one cycle where they stand.
  always @(posedge mclk) begin
    if (rd_seen) begin
      mon_e = exp_q.pop_front();
      comparisons++;
      if ((reg_rdata & mon_e.mask) !== (mon_e.exp & mon_e.mask)) begin
        num_errors++;
        $display("BAD reg_rdata expected %h seen %h", mon_e.exp & mon_e.mask,
          reg_rdata & mon_e.mask);
      end
      // A valid capture of a four-cycle reference shows two adjacent ones per nibble of its low byte.
      if (mon_e.mask == 32'h0001_0000 && mon_e.exp[16] && reg_rdata[16] === 1'b1) begin
        comparisons++;
        if (reg_rdata[7:4] !== reg_rdata[3:0] ||
          (reg_rdata[3:0] ^ {reg_rdata[1:0], reg_rdata[3:2]}) !== 4'hf) begin
          num_errors++;
          $display("BAD clock_edge_position_readback expected period 4 seen %h",
            reg_rdata[15:0]);
        end
      end
    end
    rd_seen <= reg_rd;
  end

  // Latency from pin rise to internal rise, and a count of sync pulses.
  always @(posedge mclk) begin
    tick <= tick + 1;
    pin_q <= req_pin;
    int_q <= req_int;
    if (req_pin && !pin_q) t0 <= tick;
    if (req_int === 1'b1 && int_q === 1'b0) begin
      lat <= tick - t0;
      ri_cnt <= ri_cnt + 1;
    end
    if (div_sync === 1'b1) sync_cnt <= sync_cnt + 1;
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back('{x, m});
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask

  task automatic chk(input string name, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, x, g);
    end
  endtask

  // Counts high cycles and rising edges of the first frame output over c cycles.
  task automatic cnt_fp(input int c, output int h, output int r);
    logic p;
    p = fp_out[0];
    h = 0;
    r = 0;
    repeat (c) begin
      @(posedge mclk);
      #1;
      h += int'(fp_out[0]);
      r += int'(fp_out[0] & ~p);
      p = fp_out[0];
    end
  endtask

  // Bounded wait for the next internal request rise; a miss ends the run.
  task automatic wait_int(input int c);
    int k;
    k = 0;
    while (ri_cnt == c && k < 60) begin
      @(posedge mclk);
      k++;
    end
    if (ri_cnt == c) begin
      num_errors++;
      $display("BAD request_internal expected rise seen none");
      stop_test();
    end
  endtask

  // Watchdog against a hang anywhere in the sequence.
  initial begin
    repeat (30000) @(posedge mclk);
    num_errors++;
    $display("BAD run expected end seen timeout");
    stop_test();
  end

  initial begin
    mclk = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_seen = 1'b0;
    pin_q = 1'b0;
    int_q = 1'b0;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    {num_errors, comparisons, tick, t0, lat, ri_cnt, sync_cnt} = '0;
    seed = 36;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(ADDR_CTRL, 32'h0000_0800, 32'hffff_ffff);
    rd(ADDR_DIV, 32'h0000_2004, 32'hffff_ffff);
    rd(8'h44, 32'h0, 32'hffff_ffff); // Unmapped place reads zero.
    rd(ADDR_STATUS, 32'h0, 32'h00f1_0000);
    for (b = 0; b < 4; b++) begin
      wr(ADDR_CTRL, 32'h0000_0800 | (32'(b) << 6));
      @(posedge mclk);
      #1;
      chk("request_input_bias_sel", 32'(b), {30'h0, bias_sel});
      wr(ADDR_REQDLY, 32'(b) << 6);
      rd(ADDR_STATUS, {gran[b], 24'h0}, 32'hff00_0000);
    end
    // Path codes 0 to 3, code 3 with multiplier 1 and 2, frame enable toggled alongside.
    for (b = 0; b < 5; b++) begin
      wr(ADDR_CTRL, (32'(b < 3 ? b : 3) << 11) | (32'(b < 3 ? 0 : b - 2) << 13) |
        (32'(b & 1) << 2));
      rd(ADDR_STATUS, {8'h0, 1'(b & 1), fmode[b], 20'h0}, 32'h00f0_0000);
    end
    // Each output gets its own quadrant, with random settings.
    d = 5'($random(seed)) | 5'h01;
    wr(ADDR_DIV, {15'h0, d, 12'h004});
    for (b = 0; b < 4; b++) begin
      iv = 7'($random(seed));
      qv = 7'($random(seed));
      case (b)
        0: st = 9'h17d - {2'h0, iv};
        1: st = 9'h1fc - {2'h0, qv};
        2: st = 9'h0fe - {2'h0, qv};
        default: st = 9'h07f - {2'h0, iv};
      endcase
      wr(ADDR_OUTDLY0 + 8'(4 * b), {16'h0, qv, iv, 2'(b)});
      rd(ADDR_STEP0 + 8'(4 * b), {9'h0, 14'(st) * 14'(d), st}, 32'h007f_ffff);
    end
    // Added request delay shows as the same added latency.
    wr(ADDR_CTRL, CTRL_RST);
    for (b = 0; b < 3; b++) begin
      wr(ADDR_REQDLY, (b == 2) ? 32'h9 : 32'(b));
      n0 = ri_cnt;
      i_src.pulse(20);
      wait_int(n0);
      if (b == 0) l0 = lat;
      else chk("request_delay_count", (b == 2) ? 32'h9 : 32'h1, 32'(lat - l0));
    end
    // Soft force raises the request but never syncs.
    wr(ADDR_CTRL, CTRL_RST | 32'h0000_0400);
    n0 = ri_cnt;
    l0 = sync_cnt;
    wr(ADDR_CTRL, CTRL_RST | 32'h0000_0420);
    wait_int(n0);
    repeat (20) @(posedge mclk);
    chk("request_internal", 32'h1, {31'h0, req_int});
    chk("divider_sync", 32'(l0), 32'(sync_cnt));
    wr(ADDR_CTRL, CTRL_RST | 32'h0000_0400);
    repeat (20) @(posedge mclk);
    i_src.pulse(10);
    i_src.pulse(10);
    repeat (10) @(posedge mclk);
    chk("divider_sync", 32'(l0 + 2), 32'(sync_cnt));
    // Frame pulses per mode; soft force stands in for the request.
    wr(ADDR_REQDLY, 32'h0);
    wr(ADDR_CTRL, CTRL_RST | 32'h0000_002e); // Repeater mode on the bypass path.
    repeat (4) @(posedge mclk);
    cnt_fp(8, n0, l0);
    chk("frame_pulse_out", 32'h8, 32'(n0));
    for (b = 0; b < 2; b++) begin
      wr(ADDR_CTRL, CTRL_RST | 32'h0000_0004 | (32'(1 - b) << 5));
      repeat (4) @(posedge mclk);
      cnt_fp(8, n0, l0);
      chk("frame_pulse_out", 32'(4 - 4 * b), 32'(n0));
    end
    b = $random(seed) & 3;
    wr(ADDR_CTRL, CTRL_RST | 32'h0000_0005 | (32'(b) << 15));
    wr(ADDR_CTRL, CTRL_RST | 32'h0000_0025 | (32'(b) << 15));
    cnt_fp(48, n0, l0);
    chk("frame_pulse_out", 32'(b + 1), 32'(l0));
    // A second reset in mid-run brings back the defaults.
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(ADDR_CTRL, CTRL_RST, 32'hffff_ffff);
    // Windowing: enable, clear, then short and full pulses.
    wr(ADDR_CTRL, CTRL_RST);
    wr(ADDR_REQDLY, 32'h0); // Lowest count that works.
    wr(ADDR_CTRL, CTRL_RST | 32'h0000_0100);
    wr(ADDR_CTRL, CTRL_RST | 32'h0000_0300);
    i_src.pulse(2);
    repeat (12) @(posedge mclk);
    rd(ADDR_STATUS, 32'h0, 32'h0001_0000);
    for (b = 0; b < 2; b++) begin
      i_src.pulse(24);
      rd(ADDR_STATUS, 32'h0001_0000, 32'h0001_0000);
    end
    wr(ADDR_CTRL, CTRL_RST | 32'h0000_0300);
    rd(ADDR_STATUS, 32'h0, 32'h0001_0000);
    i_src.pulse(24);
    rd(ADDR_STATUS, 32'h0001_0000, 32'h0001_0000);
    repeat (3) @(posedge mclk);
    stop_test();
  end
endmodule
